// *** aar_pkg.sv ***
package aar_pkg;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_RETRY  = 8'h04;
  localparam logic [7:0] OFS_CHAN   = 8'h08;
  localparam logic [7:0] OFS_OBS    = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_CMD    = 8'h14;
  localparam logic [7:0] OFS_REPLY  = 8'h18;

  localparam int CTRL_PRIM_RX = 0;
  localparam int CTRL_AA      = 1;
  localparam int CTRL_ACKPAY  = 2;
  localparam int CTRL_VARLEN  = 3;
  localparam int CTRL_SKIPEN  = 4;
  localparam logic [4:0] CTRL_RST = 5'h02;

  localparam int RETRY_LIMIT_LSB = 0;
  localparam int RETRY_DELAY_LSB = 4;
  localparam logic [3:0] RETRY_LIMIT_RST = 4'h3;
  localparam logic [3:0] RETRY_DELAY_RST = 4'h0;

  localparam int STAT_SENT     = 0;
  localparam int STAT_RECV     = 1;
  localparam int STAT_EXH      = 2;
  localparam int STAT_TXP      = 3;
  localparam int STAT_QCNT_LSB = 4;

  localparam int CMD_LOAD       = 0;
  localparam int CMD_LOAD_NOACK = 1;
  localparam int CMD_FLUSH      = 2;
  localparam int CMD_REUSE      = 3;

  localparam int REPLY_PIPE_LSB = 0;
  localparam int REPLY_DATA_LSB = 8;

  // ----------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------
  localparam int QDEPTH = 3;
  localparam int CLK_NS        = 10;
  localparam int RETRY_STEP_NS = 250000;
  localparam int LISTEN_NS     = 250000;
  localparam int RETRY_STEP_CYC = RETRY_STEP_NS / CLK_NS;
  localparam int LISTEN_CYC     = LISTEN_NS / CLK_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_STBY1, ST_STBY2, ST_TX, ST_LISTEN, ST_RETRY, ST_RX, ST_ACK_WAIT, ST_ACK_TX
  } aar_state_t;

  typedef struct packed {
    logic [2:0] pipe;
    logic [7:0] data;
  } aar_entry_t;

endpackage : aar_pkg

// *** aar_reply_queue.sv ***
`timescale 1ns/1ps
module aar_reply_queue (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Control
  input  wire logic              flush,
  input  wire logic              load,
  input  wire aar_pkg::aar_entry_t load_entry,
  input  wire logic              take,
  input  wire logic [2:0]        take_pipe,
  // Result
  output logic [1:0]             count,
  output logic                   hit,
  output logic [7:0]             hit_data
);

  typedef struct packed {
    aar_pkg::aar_entry_t [aar_pkg::QDEPTH-1:0] slot;
    logic [1:0]                                cnt;
    logic                                      hit;
    logic [7:0]                                data;
  } aar_q_t;

  aar_q_t s;
  aar_q_t n;

  // Slots stay in arrival order, so the lowest matching slot is the oldest.
  always_comb begin
    logic found;
    logic [1:0] idx;
    found = 1'b0;
    idx   = 2'h0;
    n = s;
    for (int i = aar_pkg::QDEPTH - 1; i >= 0; i--) begin
      if (2'(i) < s.cnt && s.slot[i].pipe == take_pipe) begin
        found = 1'b1;
        idx   = 2'(i);
      end
    end
    if (flush) begin
      n.cnt = 2'h0;
      n.hit = 1'b0;
    end else begin
      if (take) begin
        n.hit = found;
        if (found) begin
          n.data = s.slot[idx].data;
          for (int j = 0; j < aar_pkg::QDEPTH - 1; j++) begin
            if (2'(j) >= idx) begin
              n.slot[j] = s.slot[j+1];
            end
          end
          n.cnt = s.cnt - 2'h1;
        end
      end
      if (load && n.cnt < 2'(aar_pkg::QDEPTH)) begin
        n.slot[n.cnt] = load_entry;
        n.cnt         = n.cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign count    = s.cnt;
  assign hit      = s.hit;
  assign hit_data = s.data;

endmodule : aar_reply_queue

// *** aar_ctrl.sv ***
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module aar_ctrl #(
  parameter int unsigned STEP_CYC   = aar_pkg::RETRY_STEP_CYC,
  parameter int unsigned LISTEN_CYC = aar_pkg::LISTEN_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Host pin
  input  wire logic        activate,
  // Radio transmit path
  output logic             tx_start,
  output logic [1:0]       tx_pid,
  output logic             tx_no_ack,
  input  wire logic        tx_done,
  // Radio receive path
  output logic             rx_listen,
  input  wire logic        rx_addr_match,
  input  wire logic        rx_pkt_end,
  input  wire logic        rx_crc_ok,
  input  wire logic        rx_ack_payload,
  input  wire logic        rx_pkt_valid,
  input  wire logic [2:0]  rx_pipe,
  input  wire logic        rx_no_ack,
  // Acknowledge generator
  output logic             ack_start,
  output logic             ack_with_payload,
  output logic [7:0]       ack_payload
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    aar_pkg::aar_state_t state;
    logic [4:0]          ctrl;
    logic [3:0]          retry_limit;
    logic [3:0]          retry_delay;
    logic [6:0]          channel_select;
    logic [3:0]          retry_counter;
    logic [3:0]          lost_packet_counter;
    logic                data_sent_event;
    logic                data_received_event;
    logic                retry_exhausted_event;
    logic                tx_present;
    logic                tx_skip;
    logic                reuse;
    logic [1:0]          packet_sequence_id;
    logic                act_prev;
    logic [15:0]         step_cnt;
    logic [4:0]          steps;
    logic [15:0]         listen_cnt;
    logic                matched;
    logic                tx_start;
    logic                rx_listen;
    logic                ack_start;
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;
  } aar_ctrl_t;

  aar_ctrl_t  s;
  aar_ctrl_t  n;
  logic       q_load;
  logic       q_take;
  logic       q_flush;
  logic [1:0] q_count;
  logic       delay_done;
  logic       start_ok;
  logic       access;

  assign access     = psel && penable && s.pready;
  assign delay_done = (s.steps == 5'(s.retry_delay) + 5'h01);
  // A repeated packet needs a fresh rising edge on activate, so one pulse sends it once.
  assign start_ok   = activate && s.tx_present && !s.retry_exhausted_event &&
                      (!s.reuse || !s.act_prev);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic do_start;
    logic fail;
    do_start  = 1'b0;
    fail      = 1'b0;
    n         = s;
    q_load    = 1'b0;
    q_take    = 1'b0;
    q_flush   = 1'b0;
    n.act_prev  = activate;
    n.tx_start  = 1'b0;
    n.ack_start = 1'b0;
    n.pready    = psel && !penable;
    n.pslverr   = 1'b0;
    if (psel && !penable) begin
      unique case (paddr)
        aar_pkg::OFS_CTRL:   n.prdata = 32'(s.ctrl);
        aar_pkg::OFS_RETRY:  n.prdata = 32'({s.retry_delay, s.retry_limit});
        aar_pkg::OFS_CHAN:   n.prdata = 32'(s.channel_select);
        aar_pkg::OFS_OBS:    n.prdata = 32'({s.lost_packet_counter, s.retry_counter});
        aar_pkg::OFS_STATUS: n.prdata = 32'({q_count, s.tx_present, s.retry_exhausted_event,
                                              s.data_received_event, s.data_sent_event});
        aar_pkg::OFS_CMD, aar_pkg::OFS_REPLY: n.prdata = 32'h00000000;
        default: begin
          n.prdata  = 32'h00000000;
          n.pslverr = 1'b1;
        end
      endcase
    end
    if (access && pwrite) begin
      unique case (paddr)
        aar_pkg::OFS_CTRL: n.ctrl = pwdata[4:0];
        aar_pkg::OFS_RETRY: begin
          n.retry_limit = pwdata[aar_pkg::RETRY_LIMIT_LSB +: 4];
          n.retry_delay = pwdata[aar_pkg::RETRY_DELAY_LSB +: 4];
        end
        aar_pkg::OFS_CHAN: begin
          n.channel_select = pwdata[6:0];
          n.lost_packet_counter = 4'h0;
        end
        aar_pkg::OFS_STATUS: begin
          n.data_sent_event       = s.data_sent_event & ~pwdata[aar_pkg::STAT_SENT];
          n.data_received_event   = s.data_received_event & ~pwdata[aar_pkg::STAT_RECV];
          n.retry_exhausted_event = s.retry_exhausted_event & ~pwdata[aar_pkg::STAT_EXH];
        end
        aar_pkg::OFS_CMD: begin
          if (pwdata[aar_pkg::CMD_LOAD] || (pwdata[aar_pkg::CMD_LOAD_NOACK] && s.ctrl[aar_pkg::CTRL_SKIPEN])) begin
            n.tx_present = 1'b1;
            n.reuse      = 1'b0;
            n.tx_skip    = !pwdata[aar_pkg::CMD_LOAD];
          end
          if (pwdata[aar_pkg::CMD_FLUSH]) begin
            q_flush      = 1'b1;
            n.tx_present = 1'b0;
            n.reuse      = 1'b0;
          end
          // keep last packet for manual resends
          if (pwdata[aar_pkg::CMD_REUSE]) begin
            n.reuse      = 1'b1;
            n.tx_present = 1'b1;
          end
        end
        // reply stored in a free slot
        aar_pkg::OFS_REPLY: q_load = 1'b1;
        default: n.pslverr = 1'b0;
      endcase
    end
    // delay timer runs from packet end
    if ((s.state == aar_pkg::ST_LISTEN || s.state == aar_pkg::ST_RETRY) && !delay_done) begin
      if (s.step_cnt == 16'(STEP_CYC - 1)) begin
        n.step_cnt = 16'h0000;
        n.steps    = s.steps + 5'h01;
      end else begin
        n.step_cnt = s.step_cnt + 16'h0001;
      end
    end
    unique case (s.state)
      aar_pkg::ST_STBY1: begin
        if (activate && s.ctrl[aar_pkg::CTRL_PRIM_RX]) begin
          n.state     = aar_pkg::ST_RX;
          n.rx_listen = 1'b1;
        end else if (start_ok) begin
          do_start = 1'b1;
        end else if (activate && !s.tx_present) begin
          n.state = aar_pkg::ST_STBY2;
        end
      end
      aar_pkg::ST_STBY2: begin
        if (!activate || s.ctrl[aar_pkg::CTRL_PRIM_RX]) begin
          n.state = aar_pkg::ST_STBY1;
        end else if (start_ok) begin
          do_start = 1'b1;
        end
      end
      aar_pkg::ST_TX: begin
        if (tx_done) begin
          // The tx_done cycle already counts toward the delay, so the resend is not late by one.
          n.step_cnt   = 16'h0001;
          n.steps      = 5'h00;
          n.listen_cnt = 16'h0000;
          n.matched    = 1'b0;
          if (s.tx_skip || !s.ctrl[aar_pkg::CTRL_AA]) begin
            n.state           = aar_pkg::ST_STBY1;
            n.data_sent_event = 1'b1;
            n.tx_present      = s.reuse;
          end else begin
            n.state     = aar_pkg::ST_LISTEN;
            n.rx_listen = 1'b1;
          end
        end
      end
      aar_pkg::ST_LISTEN: begin
        n.listen_cnt = s.listen_cnt + 16'h0001;
        if (rx_pkt_end && (s.matched || rx_addr_match)) begin
          if (rx_crc_ok) begin
            n.data_sent_event = 1'b1;
            if (rx_ack_payload) begin
              n.data_received_event = 1'b1;
            end
            n.state      = aar_pkg::ST_STBY1;
            n.rx_listen  = 1'b0;
            n.tx_present = s.reuse;
          end else begin
            fail = 1'b1;
          end
        end else if (rx_addr_match) begin
          n.matched = 1'b1;
        end else if ((!s.matched && s.listen_cnt == 16'(LISTEN_CYC - 1)) || delay_done) begin
          fail = 1'b1;
        end
        if (fail) begin
          n.rx_listen = 1'b0;
          if (s.retry_counter == s.retry_limit) begin
            n.retry_exhausted_event = 1'b1;
            n.state                 = aar_pkg::ST_STBY1;
          end else begin
            n.state = aar_pkg::ST_RETRY;
          end
        end
      end
      aar_pkg::ST_RETRY: begin
        if (delay_done) begin
          n.state               = aar_pkg::ST_TX;
          n.tx_start            = 1'b1;
          n.retry_counter       = s.retry_counter + 4'h1;
          if (n.lost_packet_counter != 4'hF) begin
            n.lost_packet_counter = n.lost_packet_counter + 4'h1;
          end
        end
      end
      aar_pkg::ST_RX: begin
        if (!activate || !s.ctrl[aar_pkg::CTRL_PRIM_RX]) begin
          n.state     = aar_pkg::ST_STBY1;
          n.rx_listen = 1'b0;
        end else if (rx_pkt_valid) begin
          n.data_received_event = 1'b1;
          if (s.ctrl[aar_pkg::CTRL_AA] && !rx_no_ack) begin
            // payload only with both modes on
            q_take      = s.ctrl[aar_pkg::CTRL_ACKPAY] && s.ctrl[aar_pkg::CTRL_VARLEN];
            n.state     = aar_pkg::ST_ACK_WAIT;
            n.rx_listen = 1'b0;
          end
        end
      end
      aar_pkg::ST_ACK_WAIT: begin
        n.ack_start = 1'b1;
        n.state     = aar_pkg::ST_ACK_TX;
      end
      aar_pkg::ST_ACK_TX: begin
        if (tx_done) begin
          n.state     = aar_pkg::ST_RX;
          n.rx_listen = 1'b1;
        end
      end
    endcase
    if (do_start) begin
      n.state         = aar_pkg::ST_TX;
      n.tx_start      = 1'b1;
      n.retry_counter = 4'h0;
      if (!s.reuse) begin
        n.packet_sequence_id = s.packet_sequence_id + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s             <= '0;
      s.state       <= aar_pkg::ST_STBY1;
      s.ctrl        <= aar_pkg::CTRL_RST;
      s.retry_limit <= aar_pkg::RETRY_LIMIT_RST;
      s.retry_delay <= aar_pkg::RETRY_DELAY_RST;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // Reply queue
  // ----------------------------------------------------------------
  // three pending replies
  aar_reply_queue u_queue (
    .clk        (clk),
    .rst_b      (rst_b),
    .flush      (q_flush),
    .load       (q_load),
    .load_entry ({pwdata[aar_pkg::REPLY_PIPE_LSB +: 3], pwdata[aar_pkg::REPLY_DATA_LSB +: 8]}),
    .take       (q_take),
    .take_pipe  (rx_pipe),
    .count      (q_count),
    .hit        (ack_with_payload),
    .hit_data   (ack_payload)
  );

  assign prdata    = s.prdata;
  assign pready    = s.pready;
  assign pslverr   = s.pslverr;
  assign tx_start  = s.tx_start;
  assign tx_pid    = s.packet_sequence_id;
  assign tx_no_ack = s.tx_skip;
  assign rx_listen = s.rx_listen;
  assign ack_start = s.ack_start;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_ack_due;
    s.state == aar_pkg::ST_RX && activate && s.ctrl[aar_pkg::CTRL_PRIM_RX] && rx_pkt_valid;
  endsequence

  property p_ack_sent;
    s_ack_due and (s.ctrl[aar_pkg::CTRL_AA] && !rx_no_ack) |-> ##2 ack_start;
  endproperty
  a_ack_sent: assert property (p_ack_sent) else $error("acknowledge not started");

  property p_no_ack_skip;
    s_ack_due and rx_no_ack |-> ##1 !ack_start ##1 !ack_start;
  endproperty
  a_no_ack_skip: assert property (p_no_ack_skip) else $error("acknowledge sent for skip packet");

  property p_sent_event;
    s.state == aar_pkg::ST_LISTEN && rx_pkt_end && s.matched && rx_crc_ok
      |=> s.data_sent_event && s.state == aar_pkg::ST_STBY1;
  endproperty
  a_sent_event: assert property (p_sent_event) else $error("data-sent missing");

  property p_exhaust;
    s.state == aar_pkg::ST_LISTEN && n.state == aar_pkg::ST_STBY1 && !n.data_sent_event
      |=> s.retry_exhausted_event && s.retry_counter == s.retry_limit;
  endproperty
  a_exhaust: assert property (p_exhaust) else $error("exhaustion wrong");

  property p_pid_kept;
    s.state == aar_pkg::ST_RETRY && delay_done |=> tx_start && $stable(tx_pid);
  endproperty
  a_pid_kept: assert property (p_pid_kept) else $error("sequence id changed on resend");

  property p_counter_clear;
    (s.state == aar_pkg::ST_STBY1 || s.state == aar_pkg::ST_STBY2) && start_ok && !s.ctrl[aar_pkg::CTRL_PRIM_RX]
      |=> tx_start && s.retry_counter == 4'h0;
  endproperty
  a_counter_clear: assert property (p_counter_clear) else $error("retry counter not cleared");

  property p_lost_clear;
    access && pwrite && paddr == aar_pkg::OFS_CHAN |=> s.lost_packet_counter == 4'h0;
  endproperty
  a_lost_clear: assert property (p_lost_clear) else $error("lost counter not cleared");

  property p_standby2;
    s.state == aar_pkg::ST_STBY1 && activate && !s.tx_present && !s.ctrl[aar_pkg::CTRL_PRIM_RX]
      |=> s.state == aar_pkg::ST_STBY2 ##1 (s.state == aar_pkg::ST_STBY2 || !$past(activate) || s.tx_present);
  endproperty
  a_standby2: assert property (p_standby2) else $error("standby-II not entered");

  property p_skip_direct;
    s.state == aar_pkg::ST_TX && tx_done && s.tx_skip |=> s.state == aar_pkg::ST_STBY1 && !rx_listen;
  endproperty
  a_skip_direct: assert property (p_skip_direct) else $error("listened after skip packet");

endmodule : aar_ctrl

// *** aar_radio_model.sv ***
`timescale 1ns/1ps
module aar_radio_model (
  // Clock and scenario control
  input  wire logic       clk,
  input  wire logic [1:0] mode,
  input  wire logic       slow,
  // Device side
  input  wire logic       tx_start,
  input  wire logic       tx_no_ack,
  input  wire logic       ack_start,
  output logic            tx_done,
  output logic            rx_addr_match,
  output logic            rx_pkt_end,
  output logic            rx_crc_ok,
  output logic            rx_ack_payload
);
  // ------------------------------------------------------------
  // Far radio: mode 0 silent, 1 empty reply, 2 reply with data, 3 bad check.
  // ------------------------------------------------------------
  logic flip;
  logic v_crc;
  logic v_pay;
  logic was_data;
  // Qualifiers toggle outside a packet end so no stale level can be trusted.
  assign rx_crc_ok      = rx_pkt_end ? v_crc : flip;
  assign rx_ack_payload = rx_pkt_end ? v_pay : ~flip;
  always @(posedge clk) flip <= ~flip;
  initial begin
    {flip, v_crc, v_pay, tx_done, rx_addr_match, rx_pkt_end} = 6'h00;
    forever begin
      @(posedge clk);
      if (tx_start === 1'b1 || ack_start === 1'b1) begin
        was_data = (tx_start === 1'b1) && (tx_no_ack !== 1'b1);
        repeat (3) @(posedge clk);
        tx_done <= 1'b1;
        @(posedge clk);
        tx_done <= 1'b0;
        if (was_data && mode != 2'h0) begin
          repeat (slow ? 10 : 2) @(posedge clk);
          rx_addr_match <= 1'b1;
          @(posedge clk);
          rx_addr_match <= 1'b0;
          rx_pkt_end    <= 1'b1;
          v_crc         <= (mode != 2'h3);
          v_pay         <= (mode == 2'h2);
          @(posedge clk);
          rx_pkt_end    <= 1'b0;
        end
      end
    end
  end
endmodule : aar_radio_model

// *** aar_ctrl_bench.sv ***
`timescale 1ns/1ps
module aar_ctrl_bench;
  logic        clk, rst_b, psel, penable, pwrite, activate, rx_pkt_valid, rx_no_ack, slow, err;
  logic        pready, pslverr, tx_start, tx_no_ack, tx_done, rx_listen, rx_addr_match;
  logic        rx_pkt_end, rx_crc_ok, rx_ack_payload, ack_start, ack_with_payload, last_na;
  logic [7:0]  paddr, ack_payload;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  rx_pipe;
  logic [1:0]  tx_pid, mode, pid0, last_pid;
  int          num_errors, comparisons, starts, s0, gap, t_done, cyc, nlisten, l0;

  // Short counts keep the retry delay at 20 cycles per step.
  aar_ctrl #(.STEP_CYC(20), .LISTEN_CYC(20)) dut (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .activate(activate), .tx_start(tx_start), .tx_pid(tx_pid),
    .tx_no_ack(tx_no_ack), .tx_done(tx_done), .rx_listen(rx_listen), .rx_addr_match(rx_addr_match),
    .rx_pkt_end(rx_pkt_end), .rx_crc_ok(rx_crc_ok), .rx_ack_payload(rx_ack_payload),
    .rx_pkt_valid(rx_pkt_valid), .rx_pipe(rx_pipe), .rx_no_ack(rx_no_ack), .ack_start(ack_start),
    .ack_with_payload(ack_with_payload), .ack_payload(ack_payload));
  aar_radio_model radio (.clk(clk), .mode(mode), .slow(slow), .tx_start(tx_start),
    .tx_no_ack(tx_no_ack), .ack_start(ack_start), .tx_done(tx_done), .rx_addr_match(rx_addr_match),
    .rx_pkt_end(rx_pkt_end), .rx_crc_ok(rx_crc_ok), .rx_ack_payload(rx_ack_payload));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (tx_done === 1'b1) t_done <= cyc;
    if (rx_listen === 1'b1) nlisten <= nlisten + 1;
    if (tx_start === 1'b1) begin
      starts   <= starts + 1;
      gap      <= cyc - t_done;
      last_pid <= tx_pid;
      last_na  <= tx_no_ack;
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wait_stat(input logic [31:0] m);
    for (int i = 0; i < 100; i++) begin
      apb(1'b0, aar_pkg::OFS_STATUS, 32'h0);
      if ((rd & m) != 32'h0) break;
    end
  endtask : wait_stat
  // A far packet on pipe p; exp packs {ack seen, with data, data byte}.
  task automatic pkt(input logic [2:0] p, input logic na, input logic [9:0] exp);
    logic [9:0] g;
    rx_pkt_valid <= 1'b1;
    rx_pipe      <= p;
    rx_no_ack    <= na;
    @(posedge clk);
    rx_pkt_valid <= 1'b0;
    rx_pipe      <= ~p;
    rx_no_ack    <= ~na;
    g = 10'h000;
    repeat (16) begin
      @(posedge clk);
      if (ack_start === 1'b1) g = {1'b1, ack_with_payload, ack_with_payload ? ack_payload : 8'h00};
    end
    check({22'h0, g}, {22'h0, exp});
  endtask : pkt
  task automatic end_of_test;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    end_of_test();
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    {rst_b, psel, penable, pwrite, activate, rx_pkt_valid, rx_no_ack, slow} = 8'h00;
    {paddr, pwdata, rx_pipe, mode, cyc, starts, nlisten, t_done, gap} = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    apb(1'b0, aar_pkg::OFS_CTRL, 32'h0);
    check(rd, 32'h2);
    apb(1'b0, aar_pkg::OFS_RETRY, 32'h0);
    check(rd, 32'h3);
    apb(1'b0, 8'h1C, 32'h0);
    check({31'h0, err}, 32'h1);
    activate <= 1'b1;
    for (int m = 1; m < 3; m++) begin
      mode <= 2'(m);
      slow <= (m == 2);
      pid0 = last_pid;
      apb(1'b1, aar_pkg::OFS_CMD, 32'h1);
      wait_stat(32'h1);
      check(rd[3:0], (m == 1) ? 32'h1 : 32'h3);
      if (m == 2) check(last_pid, 2'(pid0 + 2'h1));
      apb(1'b1, aar_pkg::OFS_STATUS, 32'h7);
    end
    apb(1'b1, aar_pkg::OFS_RETRY, 32'h12);
    apb(1'b1, aar_pkg::OFS_CHAN, 32'h5);
    mode <= 2'h0;
    s0 = starts;
    pid0 = last_pid;
    apb(1'b1, aar_pkg::OFS_CMD, 32'h1);
    wait_stat(32'h4);
    check(rd[3:0], 32'hC);
    check(starts - s0, 32'h3);
    check(last_pid, 2'(pid0 + 2'h1));
    check(gap >= 40 && gap <= 41, 32'h1);
    apb(1'b0, aar_pkg::OFS_OBS, 32'h0);
    check(rd[7:0], 32'h22);
    apb(1'b1, aar_pkg::OFS_CHAN, 32'h7);
    apb(1'b0, aar_pkg::OFS_OBS, 32'h0);
    check(rd[7:4], 32'h0);
    apb(1'b1, aar_pkg::OFS_CMD, 32'h4);
    apb(1'b1, aar_pkg::OFS_STATUS, 32'h7);
    apb(1'b1, aar_pkg::OFS_RETRY, 32'h10);
    mode <= 2'h3;
    s0 = starts;
    apb(1'b1, aar_pkg::OFS_CMD, 32'h1);
    wait_stat(32'h4);
    check(starts - s0, 32'h1);
    apb(1'b0, aar_pkg::OFS_OBS, 32'h0);
    check(rd[3:0], 32'h0);
    apb(1'b1, aar_pkg::OFS_CMD, 32'h4);
    apb(1'b1, aar_pkg::OFS_STATUS, 32'h7);
    apb(1'b1, aar_pkg::OFS_CTRL, 32'h12);
    mode <= 2'h1;
    l0 = nlisten;
    apb(1'b1, aar_pkg::OFS_CMD, 32'h2);
    wait_stat(32'h1);
    check(rd[2:0], 32'h1);
    check({last_na, 31'(nlisten - l0)}, 32'h80000000);
    s0 = starts;
    pid0 = last_pid;
    apb(1'b1, aar_pkg::OFS_CMD, 32'h8);
    repeat (2) begin
      activate <= 1'b0;
      @(posedge clk);
      activate <= 1'b1;
      repeat (30) @(posedge clk);
    end
    check(starts - s0, 32'h2);
    check(last_pid, pid0);
    apb(1'b1, aar_pkg::OFS_CTRL, 32'h0F);
    apb(1'b1, aar_pkg::OFS_REPLY, 32'hA101);
    apb(1'b1, aar_pkg::OFS_REPLY, 32'hB202);
    apb(1'b1, aar_pkg::OFS_REPLY, 32'hC301);
    apb(1'b1, aar_pkg::OFS_REPLY, 32'hD404);
    apb(1'b0, aar_pkg::OFS_STATUS, 32'h0);
    check(rd[5:4], 32'h3);
    pkt(3'h1, 1'b0, 10'h3A1);
    pkt(3'h1, 1'b0, 10'h3C3);
    pkt(3'h3, 1'b0, 10'h200);
    pkt(3'h2, 1'b1, 10'h000);
    apb(1'b1, aar_pkg::OFS_CMD, 32'h4);
    apb(1'b0, aar_pkg::OFS_STATUS, 32'h0);
    check(rd[5:4], 32'h0);
    apb(1'b1, aar_pkg::OFS_CTRL, 32'h0D);
    pkt(3'h2, 1'b0, 10'h000);
    end_of_test();
  end
endmodule : aar_ctrl_bench
